// file: hw/ebr_array.sv
// two-port 128 x 36 storage array with bit write masks and registered read data
// assumes row, mask and data arrive already decoded from the port shape
`timescale 1ns/1ps
module ebr_array (
  input  wire logic                       core_clk,
  input  wire logic                       resetn,
  input  wire logic                       rdw_old,
  input  wire logic                       a_re,
  input  wire logic                       a_we,
  input  wire logic [ebr_pkg::ROW_W-1:0]  a_row,
  input  wire logic [ebr_pkg::DATA_W-1:0] a_mask,
  input  wire logic [ebr_pkg::DATA_W-1:0] a_wd,
  output logic      [ebr_pkg::DATA_W-1:0] a_rd,
  input  wire logic                       b_re,
  input  wire logic                       b_we,
  input  wire logic [ebr_pkg::ROW_W-1:0]  b_row,
  input  wire logic [ebr_pkg::DATA_W-1:0] b_mask,
  input  wire logic [ebr_pkg::DATA_W-1:0] b_wd,
  output logic      [ebr_pkg::DATA_W-1:0] b_rd
);

  typedef struct packed {
    logic [ebr_pkg::DATA_W-1:0] a_rd;
    logic [ebr_pkg::DATA_W-1:0] b_rd;
  } ebr_arr_state_t;

  logic [ebr_pkg::DATA_W-1:0] arr [ebr_pkg::ROWS];
  ebr_arr_state_t             s;
  ebr_arr_state_t             next_s;
  logic [ebr_pkg::DATA_W-1:0] a_new;
  logic [ebr_pkg::DATA_W-1:0] b_new;

  assign a_new = (arr[a_row] & ~a_mask) | (a_wd & a_mask);
  assign b_new = (arr[b_row] & ~b_mask) | (b_wd & b_mask);

  // no reset on the cells: contents survive reset, only the read registers clear
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < ebr_pkg::DATA_W; i++)
    begin
      if (a_we && a_mask[i])
        arr[a_row][i] <= a_wd[i];                          // RULE5
      if (b_we && b_mask[i])
        arr[b_row][i] <= b_wd[i];
    end
  end

  always_comb
  begin
    next_s = s;
    if (a_re)
    begin
      if (a_we)
        next_s.a_rd = a_new;                                // RULE14
      else if (b_we && b_row == a_row && !rdw_old)
        next_s.a_rd = (arr[a_row] & ~b_mask) | (b_wd & b_mask); // RULE15
      else
        next_s.a_rd = arr[a_row];
    end
    if (b_re)
    begin
      if (b_we)
        next_s.b_rd = b_new;                                // RULE14
      else if (a_we && a_row == b_row && !rdw_old)
        next_s.b_rd = (arr[b_row] & ~a_mask) | (a_wd & a_mask); // RULE15
      else
        next_s.b_rd = arr[b_row];
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign a_rd = s.a_rd;
  assign b_rd = s.b_rd;

endmodule // ebr_array

// file: hw/ebr_block.sv
// embedded ram block: two shaped ports, input and output registers, six modes
// assumes mode, shapes and rdw_old are static while the block is in use
`timescale 1ns/1ps
module ebr_block (
  input  wire logic                       core_clk,
  input  wire logic                       resetn,
  input  wire logic [5:0]                 mode,
  input  wire logic [3:0]                 a_shape,
  input  wire logic [3:0]                 b_shape,
  input  wire logic                       rdw_old,
  input  wire logic                       in_clr,
  input  wire logic                       out_clr,
  input  wire logic [ebr_pkg::ADDR_W-1:0] a_addr,
  input  wire logic [ebr_pkg::DATA_W-1:0] a_din,
  input  wire logic                       a_wren,
  input  wire logic                       a_rden,
  input  wire logic [ebr_pkg::LANES-1:0]  a_byteena,
  output logic      [ebr_pkg::DATA_W-1:0] a_dout,
  input  wire logic [ebr_pkg::ADDR_W-1:0] b_addr,
  input  wire logic [ebr_pkg::DATA_W-1:0] b_din,
  input  wire logic                       b_wren,
  input  wire logic                       b_rden,
  input  wire logic [ebr_pkg::LANES-1:0]  b_byteena,
  output logic      [ebr_pkg::DATA_W-1:0] b_dout,
  output logic                            fifo_full,
  output logic                            fifo_empty
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [ebr_pkg::ADDR_W-1:0] a_addr;
    logic [ebr_pkg::DATA_W-1:0] a_din;
    logic                       a_we;
    logic                       a_re;
    logic [ebr_pkg::LANES-1:0]  a_be;
    logic [ebr_pkg::ADDR_W-1:0] b_addr;
    logic [ebr_pkg::DATA_W-1:0] b_din;
    logic                       b_we;
    logic                       b_re;
    logic [ebr_pkg::LANES-1:0]  b_be;
    logic [ebr_pkg::SLOT_W-1:0] a_slot;
    logic                       a_rv;
    logic [ebr_pkg::SLOT_W-1:0] b_slot;
    logic                       b_rv;
    logic [ebr_pkg::DATA_W-1:0] a_dout;
    logic [ebr_pkg::DATA_W-1:0] b_dout;
    logic [ebr_pkg::ADDR_W-1:0] wptr;
    logic [ebr_pkg::ADDR_W-1:0] rptr;
    logic [ebr_pkg::CNT_W-1:0]  count;
    logic                       full;
    logic                       empty;
  } ebr_state_t;

  ebr_state_t                 s;
  ebr_state_t                 next_s;

  logic                       a_we_eff;
  logic                       a_re_eff;
  logic                       b_we_eff;
  logic                       b_re_eff;
  logic [ebr_pkg::ADDR_W-1:0] a_addr_eff;
  logic [ebr_pkg::ADDR_W-1:0] b_addr_eff;
  logic [ebr_pkg::ROW_W-1:0]  a_row;
  logic [ebr_pkg::ROW_W-1:0]  b_row;
  logic [ebr_pkg::SLOT_W-1:0] a_slot;
  logic [ebr_pkg::SLOT_W-1:0] b_slot;
  logic [ebr_pkg::DATA_W-1:0] a_mask;
  logic [ebr_pkg::DATA_W-1:0] a_wd;
  logic [ebr_pkg::DATA_W-1:0] b_mask;
  logic [ebr_pkg::DATA_W-1:0] b_wd;
  logic [ebr_pkg::DATA_W-1:0] a_rd;
  logic [ebr_pkg::DATA_W-1:0] b_rd;
  logic                       push;
  logic                       pop;
  logic [ebr_pkg::CNT_W-1:0]  next_count;

  // ****************************************************************
  // shape decoding
  // ****************************************************************
  // log2 of words packed into one 36-bit row
  function automatic logic [ebr_pkg::LG_W-1:0] lg_per_row(input logic [3:0] shp);
    unique case (shp)
      ebr_pkg::EBR_X1:  lg_per_row = 3'h5;
      ebr_pkg::EBR_X2:  lg_per_row = 3'h4;
      ebr_pkg::EBR_X4:  lg_per_row = 3'h3;
      ebr_pkg::EBR_X8:  lg_per_row = 3'h2;
      ebr_pkg::EBR_X16: lg_per_row = 3'h1;
      ebr_pkg::EBR_X32: lg_per_row = 3'h0;
      ebr_pkg::EBR_X9:  lg_per_row = 3'h2;
      ebr_pkg::EBR_X18: lg_per_row = 3'h1;
      ebr_pkg::EBR_X36: lg_per_row = 3'h0;
      default:          lg_per_row = 3'h0;
    endcase
  endfunction

  // parity-width shapes use all nine bits of each lane
  function automatic logic nine_wide(input logic [3:0] shp);
    nine_wide = (shp == ebr_pkg::EBR_X9) || (shp == ebr_pkg::EBR_X18) ||
                (shp == ebr_pkg::EBR_X36);                   // RULE4
  endfunction

  function automatic int word_w(input logic [3:0] shp);
    int row_bits;
    row_bits = nine_wide(shp) ? ebr_pkg::LANES * ebr_pkg::LANE_W
                              : ebr_pkg::LANES * ebr_pkg::BYTE_W;
    word_w = row_bits >> lg_per_row(shp);                    // RULE1
  endfunction

  function automatic logic mask_ok(input logic [3:0] shp);
    mask_ok = (shp == ebr_pkg::EBR_X16) || (shp == ebr_pkg::EBR_X18) ||
              (shp == ebr_pkg::EBR_X32) || (shp == ebr_pkg::EBR_X36); // RULE10
  endfunction

  function automatic logic [ebr_pkg::CNT_W-1:0] depth(input logic [3:0] shp);
    depth = ebr_pkg::CNT_W'(ebr_pkg::ROWS) << lg_per_row(shp);
  endfunction

  function automatic logic [ebr_pkg::ADDR_W-1:0] bump(
    input logic [ebr_pkg::ADDR_W-1:0] ptr,
    input logic [3:0]                 shp
  );
    bump = ({1'b0, ptr} == depth(shp) - 1'b1) ? '0 : ptr + 1'b1;
  endfunction

  function automatic logic [ebr_pkg::ROW_W-1:0] row_of(
    input logic [ebr_pkg::ADDR_W-1:0] addr,
    input logic [3:0]                 shp
  );
    row_of = ebr_pkg::ROW_W'(addr >> lg_per_row(shp));
  endfunction

  function automatic logic [ebr_pkg::SLOT_W-1:0] slot_of(
    input logic [ebr_pkg::ADDR_W-1:0] addr,
    input logic [3:0]                 shp
  );
    slot_of = ebr_pkg::SLOT_W'(addr & ~({ebr_pkg::ADDR_W{1'b1}} << lg_per_row(shp)));
  endfunction

  // logical bit to physical row bit: eight-bit shapes skip each lane's ninth bit
  function automatic int phys_bit(input logic nine, input int p);
    phys_bit = nine ? p : (p / ebr_pkg::BYTE_W) * ebr_pkg::LANE_W +
                          (p % ebr_pkg::BYTE_W);             // RULE3
  endfunction

  // returns {mask, data} for one write
  function automatic logic [2*ebr_pkg::DATA_W-1:0] pack_wr(
    input logic [3:0]                 shp,
    input logic [ebr_pkg::SLOT_W-1:0] slot,
    input logic [ebr_pkg::DATA_W-1:0] din,
    input logic [ebr_pkg::LANES-1:0]  be
  );
    logic [ebr_pkg::DATA_W-1:0] m;
    logic [ebr_pkg::DATA_W-1:0] d;
    logic                       nine;
    int                         w;
    int                         q;
    int                         k;
    m    = '0;
    d    = '0;
    nine = nine_wide(shp);
    w    = word_w(shp);
    for (int j = 0; j < ebr_pkg::DATA_W; j++)
    begin
      if (j < w)
      begin
        q = phys_bit(nine, int'(slot) * w + j);
        k = nine ? j / ebr_pkg::LANE_W : j / ebr_pkg::BYTE_W; // RULE11 RULE13
        // each lane checked alone, so any subset of enables works
        if (!mask_ok(shp) || be[k])                           // RULE5 RULE12
        begin
          m[q] = 1'b1;
          d[q] = din[j];
        end
      end
    end
    pack_wr = {m, d};
  endfunction

  function automatic logic [ebr_pkg::DATA_W-1:0] unpack_rd(
    input logic [3:0]                 shp,
    input logic [ebr_pkg::SLOT_W-1:0] slot,
    input logic [ebr_pkg::DATA_W-1:0] row
  );
    logic [ebr_pkg::DATA_W-1:0] r;
    logic                       nine;
    int                         w;
    r    = '0;
    nine = nine_wide(shp);
    w    = word_w(shp);
    for (int j = 0; j < ebr_pkg::DATA_W; j++)
      if (j < w)
        r[j] = row[phys_bit(nine, int'(slot) * w + j)];
    unpack_rd = r;
  endfunction

  // ****************************************************************
  // mode steering of the registered requests
  // ****************************************************************
  always_comb
  begin
    a_we_eff   = 1'b0;
    a_re_eff   = 1'b0;
    b_we_eff   = 1'b0;
    b_re_eff   = 1'b0;
    a_addr_eff = s.a_addr;
    b_addr_eff = s.b_addr;
    unique case (mode)                                       // RULE2
      ebr_pkg::EBR_SINGLE:
      begin
        // single port always shows the written word on its output
        a_we_eff = s.a_we;                                   // RULE6
        a_re_eff = s.a_re || s.a_we;                         // RULE14
      end
      ebr_pkg::EBR_SDP:
      begin
        a_we_eff = s.a_we;
        b_re_eff = s.b_re;                                   // RULE17
      end
      ebr_pkg::EBR_TDP:
      begin
        a_we_eff = s.a_we;
        a_re_eff = s.a_re;
        b_we_eff = s.b_we;
        b_re_eff = s.b_re;                                   // RULE17
      end
      ebr_pkg::EBR_ROM:
      begin
        a_re_eff = s.a_re;
        b_re_eff = s.b_re;
      end
      ebr_pkg::EBR_SHIFT:
      begin
        // port b reads the slot port a overwrites: the word one lap old
        a_we_eff   = s.a_we;
        a_addr_eff = s.wptr;
        b_re_eff   = s.a_we;
        b_addr_eff = s.wptr;
      end
      ebr_pkg::EBR_FIFO:
      begin
        a_we_eff   = s.a_we && !s.full;
        a_addr_eff = s.wptr;
        b_re_eff   = s.b_re && !s.empty;
        b_addr_eff = s.rptr;
      end
      default: a_we_eff = 1'b0;
    endcase
  end

  assign a_row  = row_of(a_addr_eff, a_shape);
  assign b_row  = row_of(b_addr_eff, b_shape);
  assign a_slot = slot_of(a_addr_eff, a_shape);
  assign b_slot = slot_of(b_addr_eff, b_shape);
  assign {a_mask, a_wd} = pack_wr(a_shape, a_slot, s.a_din, s.a_be);
  assign {b_mask, b_wd} = pack_wr(b_shape, b_slot, s.b_din, s.b_be);

  assign push       = (mode == ebr_pkg::EBR_FIFO) && a_we_eff;
  assign pop        = (mode == ebr_pkg::EBR_FIFO) && b_re_eff;
  assign next_count = s.count + ebr_pkg::CNT_W'(push) - ebr_pkg::CNT_W'(pop);

  ebr_array u_array (
    .core_clk (core_clk),
    .resetn   (resetn),
    .rdw_old  (rdw_old || mode == ebr_pkg::EBR_SHIFT),
    .a_re     (a_re_eff),
    .a_we     (a_we_eff),
    .a_row    (a_row),
    .a_mask   (a_mask),
    .a_wd     (a_wd),
    .a_rd     (a_rd),
    .b_re     (b_re_eff),
    .b_we     (b_we_eff),
    .b_row    (b_row),
    .b_mask   (b_mask),
    .b_wd     (b_wd),
    .b_rd     (b_rd)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    next_s = s;

    // input registers
    if (in_clr)                                              // RULE16
    begin
      next_s.a_addr = '0;
      next_s.a_din  = '0;
      next_s.a_we   = 1'b0;
      next_s.a_re   = 1'b1;                                  // RULE9
      next_s.a_be   = '1;                                    // RULE8
      next_s.b_addr = '0;
      next_s.b_din  = '0;
      next_s.b_we   = 1'b0;
      next_s.b_re   = 1'b1;                                  // RULE9
      next_s.b_be   = '1;                                    // RULE8
    end
    else
    begin
      next_s.a_addr = a_addr;                                // RULE19
      next_s.a_din  = a_din;
      next_s.a_we   = a_wren;
      next_s.a_re   = a_rden;
      next_s.a_be   = a_byteena;                             // RULE7
      next_s.b_addr = b_addr;
      next_s.b_din  = b_din;
      next_s.b_we   = b_wren;
      next_s.b_re   = b_rden;
      next_s.b_be   = b_byteena;
    end

    // word position travels alongside the array read
    next_s.a_slot = a_slot;
    next_s.a_rv   = a_re_eff;
    next_s.b_slot = b_slot;
    next_s.b_rv   = b_re_eff;

    // output registers hold their word while reads are off
    if (out_clr)                                             // RULE16
    begin
      next_s.a_dout = '0;
      next_s.b_dout = '0;
    end
    else
    begin
      if (s.a_rv)
        next_s.a_dout = unpack_rd(a_shape, s.a_slot, a_rd);
      if (s.b_rv)
        next_s.b_dout = unpack_rd(b_shape, s.b_slot, b_rd);  // RULE17
    end

    // pointers for shift and fifo modes
    if (push || (mode == ebr_pkg::EBR_SHIFT && a_we_eff))
      next_s.wptr = bump(s.wptr, a_shape);
    if (pop)
      next_s.rptr = bump(s.rptr, a_shape);
    next_s.count = next_count;
    next_s.full  = (next_count == depth(a_shape));
    next_s.empty = (next_count == '0);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s       <= '0;                                         // RULE18
      s.a_re  <= 1'b1;
      s.b_re  <= 1'b1;
      s.a_be  <= '1;
      s.b_be  <= '1;
      s.empty <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign a_dout     = s.a_dout;
  assign b_dout     = s.b_dout;
  assign fifo_full  = s.full;
  assign fifo_empty = s.empty;

endmodule // ebr_block

// file: hw/ebr_pkg.sv
// constants and types shared by the embedded ram block and its storage array
// assumes one clock domain; all shapes share one 128-row array of four 9-bit lanes
//
// Contract
// [RULE1] 4608 bits, shapes 4Kx1 through 128x36
// [RULE2] single, simple dual, true dual, shift, rom, fifo
// [RULE3] one parity bit per byte, 512 bits
// [RULE4] parity positions usable as data: x9/x18/x36
// [RULE5] only enabled byte lanes are written
// [RULE6] write happens only under write strobe
// [RULE7] mask default all ones: strobe alone governs
// [RULE8] input clear sets byte enables to ones
// [RULE9] input clear sets read enable high
// [RULE10] byte mask only at 16/18/32/36 widths
// [RULE11] x18/x36 lanes are nine bits wide
// [RULE12] any subset of mask bits is accepted
// [RULE13] x16/x32 lanes are eight bits wide
// [RULE14] same-port read during write returns new data
// [RULE15] cross-port collision gives unknown or old data; code gives new data when rdw_old is low outside shift mode, old data otherwise
// [RULE16] clears on input and output registers
// [RULE17] read and write widths may differ
// [RULE18] outputs read zero after power-up
// [RULE19] all inputs sampled on rising clock edge; mode, shapes and rdw_old are used unregistered
package ebr_pkg;

  localparam int TOTAL_BITS  = 4608;
  localparam int PARITY_BITS = 512;
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 36;
  localparam int ROWS        = 128;
  localparam int ROW_W       = 7;
  localparam int SLOT_W      = 5;
  localparam int LANES       = 4;
  localparam int BYTE_W      = 8;
  localparam int LANE_W      = 9;
  localparam int CNT_W       = 13;
  localparam int LG_W        = 3;

  // operating modes, one-hot
  typedef enum logic [5:0] {
    EBR_SINGLE = 6'h01,
    EBR_SDP    = 6'h02,
    EBR_TDP    = 6'h04,
    EBR_ROM    = 6'h08,
    EBR_SHIFT  = 6'h10,
    EBR_FIFO   = 6'h20
  } ebr_mode_t;

  // port shapes, depth x width
  typedef enum logic [3:0] {
    EBR_X1  = 4'h0,
    EBR_X2  = 4'h1,
    EBR_X4  = 4'h2,
    EBR_X8  = 4'h3,
    EBR_X16 = 4'h4,
    EBR_X32 = 4'h5,
    EBR_X9  = 4'h6,
    EBR_X18 = 4'h7,
    EBR_X36 = 4'h8
  } ebr_shape_t;

endpackage

// file: sim/ebr_block_sva.sv
// port checker for the embedded ram block
// assumes one clock domain; bound to every ebr_block instance
`timescale 1ns/1ps
module ebr_block_sva (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [5:0]  mode,
  input wire logic [3:0]  a_shape,
  input wire logic        in_clr,
  input wire logic        out_clr,
  input wire logic [35:0] a_din,
  input wire logic        a_wren,
  input wire logic        a_rden,
  input wire logic [3:0]  a_byteena,
  input wire logic        b_wren,
  input wire logic        b_rden,
  input wire logic [35:0] a_dout,
  input wire logic [35:0] b_dout,
  input wire logic        fifo_full,
  input wire logic        fifo_empty
);
  // ****************
  // settle counter
  // ****************
  // reset state holds read enable high, so early outputs may still move
  logic [2:0] up;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      up <= 3'h0;
    else if (up != 3'h7)
      up <= up + 3'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_rst_out;
    $rose(resetn) |-> a_dout == 36'h0 && b_dout == 36'h0 && fifo_empty && !fifo_full;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared at reset");
  property p_out_clr;
    out_clr |=> a_dout == 36'h0 && b_dout == 36'h0;
  endproperty
  a_out_clr: assert property (p_out_clr) else $error("output clear ignored");
  property p_hold;
    up == 3'h7 && mode == 6'h04 && !$past(a_rden, 3) && !$past(in_clr, 3) && !$past(out_clr) |-> $stable(a_dout);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_rdw_new;
    mode == 6'h04 && a_shape == 4'h8 && a_wren && a_rden && a_byteena == 4'hf && !b_wren && !in_clr
      |-> ##3 ($past(out_clr) || a_dout == $past(a_din, 3));
  endproperty
  a_rdw_new: assert property (p_rdw_new) else $error("same port read did not return new data");
  property p_x8;
    up == 3'h7 && a_shape == 4'h3 |-> a_dout[35:8] == 28'h0;
  endproperty
  a_x8: assert property (p_x8) else $error("narrow word not in low bits");
  property p_x32;
    up == 3'h7 && a_shape == 4'h5 |-> a_dout[35:32] == 4'h0;
  endproperty
  a_x32: assert property (p_x32) else $error("x32 word has parity bits set");
  property p_fifo_excl;
    !(fifo_full && fifo_empty);
  endproperty
  a_fifo_excl: assert property (p_fifo_excl) else $error("fifo full and empty together");
  property p_push;
    mode == 6'h20 && a_wren && !b_rden && !in_clr |-> ##[1:2] !fifo_empty;
  endproperty
  a_push: assert property (p_push) else $error("push left fifo empty");
  property p_empty_stay;
    mode == 6'h20 && $past(mode) == 6'h20 && fifo_empty && !a_wren && !$past(a_wren) |=> fifo_empty;
  endproperty
  a_empty_stay: assert property (p_empty_stay) else $error("empty fifo left empty state");
  c_rdw: cover property (mode == 6'h04 && a_wren && a_rden);
  c_pop: cover property (mode == 6'h20 && b_rden && !fifo_empty);
  c_clr: cover property (in_clr && !a_rden);
endmodule // ebr_block_sva
bind ebr_block ebr_block_sva u_sva (.core_clk(core_clk), .resetn(resetn), .mode(mode), .a_shape(a_shape),
  .in_clr(in_clr), .out_clr(out_clr), .a_din(a_din), .a_wren(a_wren), .a_rden(a_rden), .a_byteena(a_byteena),
  .b_wren(b_wren), .b_rden(b_rden), .a_dout(a_dout), .b_dout(b_dout), .fifo_full(fifo_full),
  .fifo_empty(fifo_empty));

// file: sim/ebr_fabric.sv
// fabric user logic model driving both request ports
// assumes calls at a rising edge; outputs change by non-blocking assignment
`timescale 1ns/1ps
module ebr_fabric (
  input  wire logic        core_clk,
  output logic      [11:0] a_addr,
  output logic      [35:0] a_din,
  output logic             a_wren,
  output logic             a_rden,
  output logic      [3:0]  a_byteena,
  output logic      [11:0] b_addr,
  output logic      [35:0] b_din,
  output logic             b_wren,
  output logic             b_rden,
  output logic      [3:0]  b_byteena
);
  // ****************
  // request tasks
  // ****************
  initial
  begin
    {a_addr, a_din, a_wren, a_rden, a_byteena} = '0;
    {b_addr, b_din, b_wren, b_rden, b_byteena} = '0;
  end
  // whole request moves at one edge and stands until the next call
  task automatic set(input logic p, w, r, input logic [11:0] ad, input logic [35:0] dv, input logic [3:0] e);
    if (p)
      {b_wren, b_rden, b_addr, b_din, b_byteena} <= {w, r, ad, dv, e};
    else
      {a_wren, a_rden, a_addr, a_din, a_byteena} <= {w, r, ad, dv, e};
  endtask
  // released strobes drop and other lines flip so stale values never look valid
  task automatic idle(input logic p);
    if (p)
      {b_wren, b_rden, b_addr, b_din, b_byteena} <= {2'b00, ~b_addr, ~b_din, ~b_byteena};
    else
      {a_wren, a_rden, a_addr, a_din, a_byteena} <= {2'b00, ~a_addr, ~a_din, ~a_byteena};
  endtask
endmodule // ebr_fabric

// file: sim/tb_top.sv
// self-checking bench for the embedded ram block
// assumes the fabric model drives the request ports
`timescale 1ns/1ps
module tb_top;
  logic        core_clk, resetn, rdw_old, in_clr, out_clr;
  logic [5:0]  mode;
  logic [3:0]  a_shape, b_shape, a_byteena, b_byteena, be;
  logic [11:0] a_addr, b_addr;
  logic [35:0] a_din, b_din, a_dout, b_dout, d;
  logic        a_wren, a_rden, b_wren, b_rden, fifo_full, fifo_empty;
  logic [6:0]  r;
  logic [35:0] m [128];
  logic [35:0] q [$];
  int          failures, checks_done, cycles, seed;
  ebr_block dut (.core_clk(core_clk), .resetn(resetn), .mode(mode), .a_shape(a_shape), .b_shape(b_shape),
    .rdw_old(rdw_old), .in_clr(in_clr), .out_clr(out_clr), .a_addr(a_addr), .a_din(a_din), .a_wren(a_wren),
    .a_rden(a_rden), .a_byteena(a_byteena), .a_dout(a_dout), .b_addr(b_addr), .b_din(b_din), .b_wren(b_wren),
    .b_rden(b_rden), .b_byteena(b_byteena), .b_dout(b_dout), .fifo_full(fifo_full), .fifo_empty(fifo_empty));
  ebr_fabric u_fab (.core_clk(core_clk), .a_addr(a_addr), .a_din(a_din), .a_wren(a_wren), .a_rden(a_rden),
    .a_byteena(a_byteena), .b_addr(b_addr), .b_din(b_din), .b_wren(b_wren), .b_rden(b_rden),
    .b_byteena(b_byteena));
  // ****************
  // model and tasks
  // ****************
  function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] e, logic nine);
    for (int k = 0; k < 4; k++)
      if (e[k] && nine)
        o[9*k +: 9] = n[9*k +: 9];
      else if (e[k])
        o[8*k +: 8] = n[8*k +: 8];
    return o;
  endfunction
  task automatic chk(logic [35:0] got, logic [35:0] exp_v);
    checks_done++;
    if (got !== exp_v)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp_v);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(logic p, logic [11:0] ad, logic [35:0] dv, logic [3:0] e);
    @(posedge core_clk);
    u_fab.set(p, 1'b1, 1'b0, ad, dv, e);
    @(posedge core_clk);
    u_fab.idle(p);
  endtask
  // answer lands two edges after the capture edge
  task automatic rd(logic p, logic [11:0] ad, logic [35:0] exp_v);
    @(posedge core_clk);
    u_fab.set(p, 1'b0, 1'b1, ad, 36'h0, 4'hf);
    @(posedge core_clk);
    u_fab.idle(p);
    repeat (2) @(posedge core_clk);
    #1 chk(p ? b_dout : a_dout, exp_v);
  endtask
  // outputs cleared first so stale wide words never meet a new shape
  task automatic cfg(logic [5:0] md, logic [3:0] sa, logic [3:0] sb);
    @(posedge core_clk);
    out_clr <= 1'b1;
    @(posedge core_clk);
    out_clr <= 1'b0;
    {mode, a_shape, b_shape} <= {md, sa, sb};
    #1 chk({a_dout, b_dout} == 72'h0, 36'h1);
  endtask
  task automatic lanes(logic nine, logic [35:0] wm);
    for (int i = 0; i < 8; i++)
    begin
      m[i] = 36'({$random(seed), $random(seed)}) & wm;
      wr(i[0], 12'(i), m[i], 4'hf);
    end
    for (int i = 0; i < 24; i++)
    begin
      r = 7'($random(seed) & 7);
      d = 36'({$random(seed), $random(seed)}) & wm;
      be = 4'($random(seed));
      wr(r[0], 12'(r), d, be);
      m[r] = merge(m[r], d, be, nine);
    end
    @(posedge core_clk);
    u_fab.set(1'b0, 1'b0, 1'b0, 12'h3, ~m[3], 4'hf);
    @(posedge core_clk);
    u_fab.idle(1'b0);
    for (int i = 0; i < 8; i++)
      rd(i[1], 12'(i), m[i]);
  endtask
  // ****************
  // clock, timeout, sequence
  // ****************
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      failures++;
      $display("Error at %0t: timeout", $time);
      results();
    end
  end
  initial
  begin
    {seed, failures, checks_done, cycles} = {32'h7765, 96'h0};
    {resetn, rdw_old, in_clr, out_clr, mode, a_shape, b_shape} = {4'b0100, 6'h04, 4'h8, 4'h8};
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    #1 chk({a_dout, b_dout} == 72'h0, 36'h1);
    chk({fifo_full, fifo_empty}, 36'h1);
    lanes(1'b1, 36'hf_ffff_ffff);
    cfg(6'h04, 4'h8, 4'h7);
    for (int i = 0; i < 4; i++)
    begin
      rd(1'b1, 12'(2*i), {18'h0, m[i][17:0]});
      rd(1'b1, 12'(2*i+1), {18'h0, m[i][35:18]});
    end
    cfg(6'h04, 4'h8, 4'h8);
    d = 36'({$random(seed), $random(seed)});
    @(posedge core_clk);
    u_fab.set(1'b0, 1'b1, 1'b1, 12'h5, d, 4'hf);
    u_fab.set(1'b1, 1'b0, 1'b1, 12'h5, 36'h0, 4'hf);
    @(posedge core_clk);
    u_fab.idle(1'b0);
    u_fab.idle(1'b1);
    repeat (2) @(posedge core_clk);
    #1 chk(a_dout, d);
    chk(b_dout, m[5]);
    m[5] = d;
    rd(1'b0, 12'h6, m[6]);
    @(posedge core_clk);
    in_clr <= 1'b1;
    @(posedge core_clk);
    in_clr <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk(a_dout, m[0]);
    chk(b_dout, m[0]);
    cfg(6'h04, 4'h5, 4'h5);
    lanes(1'b0, 36'h0_ffff_ffff);
    cfg(6'h04, 4'h3, 4'h3);
    wr(1'b0, 12'h5, 36'ha5, 4'hf);
    wr(1'b0, 12'h5, 36'h3c, 4'h0);
    rd(1'b0, 12'h5, 36'h3c);
    cfg(6'h08, 4'h5, 4'h5);
    wr(1'b0, 12'h0, 36'h5_a5a5_a5a5, 4'hf);
    rd(1'b0, 12'h0, m[0]);
    cfg(6'h01, 4'h5, 4'h5);
    wr(1'b0, 12'h0, d, 4'hf);
    repeat (2) @(posedge core_clk);
    #1 chk(a_dout, {4'h0, d[31:0]});
    cfg(6'h02, 4'h5, 4'h5);
    wr(1'b1, 12'h0, ~d, 4'hf);
    rd(1'b1, 12'h0, {4'h0, d[31:0]});
    @(posedge core_clk);
    resetn <= 1'b0;
    @(posedge core_clk);
    resetn <= 1'b1;
    cfg(6'h20, 4'h8, 4'h8);
    #1 chk(fifo_empty, 36'h1);
    for (int i = 0; i < 3; i++)
    begin
      q.push_back(36'({$random(seed), $random(seed)}));
      wr(1'b0, 12'h0, q[i], 4'hf);
    end
    @(posedge core_clk);
    #1 chk(fifo_empty, 36'h0);
    for (int i = 0; i < 3; i++)
      rd(1'b1, 12'h0, q[i]);
    chk(fifo_empty, 36'h1);
    cfg(6'h10, 4'h5, 4'h5);
    for (int i = 0; i < 129; i++)
      wr(1'b0, 12'h0, 36'(i + 1), 4'hf);
    repeat (2) @(posedge core_clk);
    #1 chk(b_dout, 36'h1);
    results();
  end
endmodule // tb_top
